/* File: hdl/rsf_top.sv */
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "rsf_params.svh"
module rsf_top
	import rsf_pkg::*;
#(
	parameter int BROWN_EXT_CYC = `RSF_BROWN_EXT_CYC,
	parameter int DELAY_UNIT_CYC = `RSF_DELAY_UNIT_CYC // one millisecond of clock cycles
) (
	input wire logic clk, // system clock, 40 MHz
	input wire logic sys_rst, // power-on reset, sync, active high
	input wire logic brown_out_low, // supply below brown_out_threshold, async
	input wire logic external_reset_pin, // external reset pin, low = reset
	input wire logic reset_instr, // software reset instruction strobe
	input wire logic watchdog_timeout, // watchdog time-out pulse
	input wire logic cpu_sleep_idle, // core in sleep or idle
	input wire logic power_save_sleep, // power save sleep instruction
	input wire logic power_save_idle, // power save idle instruction
	input wire logic watchdog_clear_instruction, // watchdog clear strobe
	input wire logic hard_trap_req, // hard trap request strobe
	input wire logic [3:0] hard_trap_level, // level of that trap
	input wire logic [3:0] active_trap_level, // level now processed, 0 none
	input wire logic [15:0] pin_select_regs, // pin-select control word
	input wire logic [15:0] pin_select_shadow, // its shadow copy
	input wire logic opcode_valid, // instruction about to execute
	input wire logic [7:0] opcode_upper, // upper instruction byte
	input wire logic [3:0] ptr_reg_sel, // working reg used as pointer
	input wire logic ptr_use, // pointer use strobe
	input wire logic [3:0] wreg_wr_sel, // working reg written
	input wire logic wreg_wr, // working reg write strobe
	input wire logic program_flow_change, // branch/call/return
	input wire logic vector_flow_change, // vector load
	input wire logic flow_target_restricted, // target is protected
	input wire logic [2:0] initial_clock_select, // configured clock source
	input wire logic [2:0] current_clock_select, // running clock source
	input wire logic hclk_unused, // spare, tie low
	input wire logic hsel, // ahb select
	input wire logic [7:0] haddr, // ahb address
	input wire logic [1:0] htrans, // ahb transfer type
	input wire logic hwrite, // ahb write
	input wire logic [2:0] hsize, // ahb size
	input wire logic [31:0] hwdata, // ahb write data
	input wire logic hready, // ahb ready in
	output logic [31:0] hrdata, // ahb read data
	output logic hreadyout, // ahb ready out
	output logic hresp, // ahb response, always okay
	output logic system_reset_n, // system reset, low active
	output logic wreg_clear, // clear working registers
	output logic wake_req, // watchdog wake from sleep/idle
	output logic [2:0] clock_select, // clock source after reset
	output logic [23:0] reset_vector // fetch address after release
);
	// ==========================================
	// pin conditioning
	logic ext_filt;
	logic brown_s1_q;
	logic brown_s2_q;
	always_ff @(posedge clk) begin
		brown_s1_q <= brown_out_low;
		brown_s2_q <= brown_s1_q;
	end
	rsf_sync #(.FILT(`RSF_EXTRST_FILT_CYC)) u_ext (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_in(external_reset_pin),
		.rst_val(1'b1),
		.filt_out(ext_filt)
	);
	// ==========================================
	// register state
	rsf_flags_t flags_q;
	rsf_flags_t flags_d;
	logic [2:0] delay_sel_q;
	logic [15:0] wreg_init_q;
	logic [2:0] clk_sel_q;
	rsf_state_t st_q;
	logic ext_prev_q;
	// ==========================================
	// reset causes
	wire [15:0] delay_ms = (delay_sel_q == 3'h0) ? 16'h0 : (16'h1 << delay_sel_q);
	wire [31:0] cold_load = 32'(BROWN_EXT_CYC) + 32'(delay_ms) * 32'(DELAY_UNIT_CYC);
	wire cold_done;
	wire ext_fall = ext_prev_q && !ext_filt;
	wire wdt_rst = watchdog_timeout && !cpu_sleep_idle;
	wire trap_conf = hard_trap_req && hard_trap_level >= `RSF_HARD_TRAP_MIN && active_trap_level > hard_trap_level;
	wire cfg_mis = pin_select_regs != pin_select_shadow;
	wire ill_op = opcode_valid && opcode_upper == `RSF_ILLEGAL_UPPER;
	wire uninit = ptr_use && !wreg_init_q[ptr_reg_sel] && !(ptr_reg_sel == 4'hf);
	wire sec_rst = (program_flow_change || vector_flow_change) && flow_target_restricted;
	wire illegal = ill_op || uninit || sec_rst;
	wire warm = ext_fall || reset_instr || wdt_rst || trap_conf || cfg_mis || illegal;
	// ==========================================
	// bus decode
	logic ph_wr_q;
	logic ph_rd_q;
	logic [7:0] ph_addr_q;
	wire bus_go = hsel && htrans[1] && hready;
	wire wr_flags = ph_wr_q && ph_addr_q == `RSF_ADDR_FLAGS;
	wire wr_cfg = ph_wr_q && ph_addr_q == `RSF_ADDR_CFG;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ph_wr_q <= 1'b0;
			ph_rd_q <= 1'b0;
			ph_addr_q <= 8'h00;
		end else begin
			ph_wr_q <= bus_go && hwrite;
			ph_rd_q <= bus_go && !hwrite;
			ph_addr_q <= haddr;
		end
	end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hrdata <= 32'h0;
		end else if (bus_go && !hwrite) begin
			case (haddr)
				`RSF_ADDR_FLAGS: hrdata <= {16'h0, flags_q};
				`RSF_ADDR_CFG: hrdata <= {29'h0, delay_sel_q};
				`RSF_ADDR_STAT: hrdata <= {28'h0, clk_sel_q, st_q != RSF_RUN};
				default: hrdata <= 32'h0;
			endcase
		end
	end
	// ==========================================
	// sequencer
	rsf_delay u_cold (
		.clk(clk),
		.sys_rst(sys_rst),
		.restart(brown_s2_q),
		.load(cold_load),
		.done(cold_done)
	);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= RSF_HOLD_COLD;
			ext_prev_q <= 1'b1;
		end else begin
			ext_prev_q <= ext_filt;
			case (st_q)
				RSF_RUN: begin
					if (brown_s2_q) begin
						st_q <= RSF_HOLD_COLD;
					end else if (warm) begin
						st_q <= RSF_HOLD_WARM;
					end
				end
				RSF_HOLD_COLD: begin
					if (cold_done) begin
						st_q <= RSF_RUN;
					end
				end
				RSF_HOLD_WARM: begin
					if (brown_s2_q) begin
						st_q <= RSF_HOLD_COLD;
					end else if (ext_filt) begin
						st_q <= RSF_RUN;
					end
				end
				default: st_q <= RSF_HOLD_COLD;
			endcase
		end
	end
	// watchdog reset also drops reset combinationally, without waiting for the state
	assign system_reset_n = st_q == RSF_RUN && !wdt_rst && !brown_s2_q;
	assign wake_req = watchdog_timeout && cpu_sleep_idle;
	assign wreg_clear = st_q != RSF_RUN;
	assign reset_vector = `RSF_RESET_VECTOR;
	assign clock_select = clk_sel_q;
	// ==========================================
	// clock source and working register tracking
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			clk_sel_q <= `RSF_CFG_RESET;
			delay_sel_q <= `RSF_CFG_RESET;
		end else begin
			if (st_q == RSF_HOLD_COLD) begin
				clk_sel_q <= initial_clock_select;
			end else if (st_q == RSF_RUN) begin
				clk_sel_q <= current_clock_select;
			end
			if (wr_cfg) begin
				delay_sel_q <= hwdata[2:0];
			end
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst || st_q != RSF_RUN) begin
			wreg_init_q <= 16'h8000;
		end else if (wreg_wr) begin
			wreg_init_q[wreg_wr_sel] <= 1'b1;
		end
	end
	// ==========================================
	// flags: hardware set wins over software write
	always_comb begin
		flags_d = flags_q;
		if (wr_flags) begin
			flags_d = hwdata[15:0] & `RSF_FLAG_MASK;
		end
		if (watchdog_clear_instruction || power_save_sleep || power_save_idle) begin
			flags_d[`RSF_BIT_WATCHDOG] = 1'b0;
		end
		if (power_save_sleep) begin
			flags_d[`RSF_BIT_SLEEP] = 1'b1;
		end
		if (power_save_idle) begin
			flags_d[`RSF_BIT_IDLE] = 1'b1;
		end
		if (st_q == RSF_RUN) begin
			if (ext_fall) flags_d[`RSF_BIT_EXTERNAL] = 1'b1;
			if (reset_instr) flags_d[`RSF_BIT_SOFT] = 1'b1;
			if (watchdog_timeout) flags_d[`RSF_BIT_WATCHDOG] = 1'b1;
			if (trap_conf) flags_d[`RSF_BIT_TRAP] = 1'b1;
			if (cfg_mis) flags_d[`RSF_BIT_MISMATCH] = 1'b1;
			if (illegal) flags_d[`RSF_BIT_ILLEGAL] = 1'b1;
		end
		if (brown_s2_q) begin
			flags_d = (flags_q & (16'h1 << `RSF_BIT_EXTERNAL)) | (16'h1 << `RSF_BIT_BROWN_OUT);
			flags_d[`RSF_BIT_POR] = flags_q[`RSF_BIT_POR];
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			flags_q <= `RSF_FLAGS_POR_VALUE;
		end else begin
			flags_q <= flags_d;
		end
	end
	wire unused_ok = hclk_unused ^ ^hsize ^ ph_rd_q ^ htrans[0];
endmodule : rsf_top
`default_nettype wire

/* File: inc/rsf_params.svh */
`ifndef RSF_PARAMS_SVH
`define RSF_PARAMS_SVH
// ==========================================
// register map
`define RSF_ADDR_FLAGS 8'h00
`define RSF_ADDR_CFG 8'h04
`define RSF_ADDR_STAT 8'h08
// ==========================================
// flag bit positions
`define RSF_BIT_POR 0
`define RSF_BIT_BROWN_OUT 1
`define RSF_BIT_IDLE 2
`define RSF_BIT_SLEEP 3
`define RSF_BIT_WATCHDOG 4
`define RSF_BIT_SOFT 6
`define RSF_BIT_EXTERNAL 7
`define RSF_BIT_MISMATCH 9
`define RSF_BIT_ILLEGAL 14
`define RSF_BIT_TRAP 15
`define RSF_FLAG_MASK 16'hc2df
`define RSF_FLAGS_POR_VALUE 16'h0003
// ==========================================
// timing
`define RSF_CLK_HZ 40000000
`define RSF_BROWN_EXT_US 100
`define RSF_BROWN_EXT_CYC ((`RSF_BROWN_EXT_US * (`RSF_CLK_HZ / 1000000)))
`define RSF_DELAY_UNIT_CYC (`RSF_CLK_HZ / 1000)
`define RSF_HARD_TRAP_MIN 4'hd
`define RSF_EXTRST_FILT_CYC 4
`define RSF_CFG_RESET 3'h0
`define RSF_RESET_VECTOR 24'h000000
`define RSF_ILLEGAL_UPPER 8'h3f
`endif

/* File: inc/rsf_pkg.sv */
package rsf_pkg;
	typedef enum logic [1:0] {
		RSF_RUN,
		RSF_HOLD_COLD,
		RSF_HOLD_WARM
	} rsf_state_t;
	typedef logic [15:0] rsf_flags_t;
endpackage : rsf_pkg

/* File: hdl/rsf_sync.sv */
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser plus a hold filter for a pin input
module rsf_sync #(
	parameter int FILT = 4
) (
	input wire logic clk, // system clock
	input wire logic sys_rst, // sync reset
	input wire logic pin_in, // raw pin level
	input wire logic rst_val, // unused; filt_out always resets high
	output logic filt_out // filtered level
);
	logic s1_q;
	logic s2_q;
	logic [7:0] cnt_q;
	always_ff @(posedge clk) begin
		s1_q <= pin_in;
		s2_q <= s1_q;
	end
	// ==========================================
	// level only accepted after it has stood FILT cycles
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q <= 8'h00;
			filt_out <= 1'b1;
		end else if (s2_q == filt_out) begin
			cnt_q <= 8'h00;
		end else if (cnt_q == 8'(FILT - 1)) begin
			cnt_q <= 8'h00;
			filt_out <= s2_q;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
	wire unused_ok = rst_val;
endmodule : rsf_sync
`default_nettype wire

/* File: hdl/rsf_delay.sv */
`timescale 1ns/100ps
`default_nettype none
// down-counter that restarts whenever restart is high
module rsf_delay (
	input wire logic clk, // system clock
	input wire logic sys_rst, // sync reset
	input wire logic restart, // reload and hold
	input wire logic [31:0] load, // cycles to wait
	output logic done // delay expired
);
	logic [31:0] cnt_q;
	always_ff @(posedge clk) begin
		if (sys_rst || restart) begin
			cnt_q <= load;
		end else if (cnt_q != 32'h0) begin
			cnt_q <= cnt_q - 32'h1;
		end
	end
	assign done = !restart && (cnt_q == 32'h0);
endmodule : rsf_delay
`default_nettype wire

/* File: verif/rsf_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// reset source checks, seen from the top ports only
module rsf_monitor (
	input wire logic clk, // system clock
	input wire logic sys_rst, // sync reset
	input wire logic brown_out_low, // supply low
	input wire logic external_reset_pin, // reset pin
	input wire logic reset_instr, // software reset
	input wire logic watchdog_timeout, // watchdog pulse
	input wire logic cpu_sleep_idle, // sleep or idle
	input wire logic [15:0] pin_select_regs, // pin select
	input wire logic [15:0] pin_select_shadow, // shadow
	input wire logic opcode_valid, // opcode strobe
	input wire logic [7:0] opcode_upper, // upper byte
	input wire logic hreadyout, // ahb ready
	input wire logic hresp, // ahb response
	input wire logic system_reset_n, // system reset
	input wire logic wreg_clear, // clear working regs
	input wire logic wake_req, // wake request
	input wire logic [23:0] reset_vector // fetch address
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	AST_WDT: assert property (watchdog_timeout && !cpu_sleep_idle |-> !system_reset_n)
		else $error("watchdog did not reset");
	AST_WAKE: assert property (watchdog_timeout && cpu_sleep_idle |-> wake_req ##1 system_reset_n)
		else $error("watchdog in sleep did not only wake");
	AST_SOFT_RST: assert property ($past(system_reset_n) && reset_instr && external_reset_pin
		|-> ##[0:1] !system_reset_n ##[1:3] system_reset_n)
		else $error("software reset pulse wrong");
	AST_ILL: assert property ($past(system_reset_n) && opcode_valid && opcode_upper == 8'h3f
		|-> ##[0:1] !system_reset_n)
		else $error("illegal opcode did not reset");
	AST_MISMATCH: assert property ($past(system_reset_n) && pin_select_regs != pin_select_shadow
		|-> ##[0:1] !system_reset_n)
		else $error("mismatch did not reset");
	AST_BROWN: assert property (brown_out_low [*4] |-> !system_reset_n)
		else $error("low supply not held in reset");
	AST_RESTART: assert property ($fell(brown_out_low) |-> !system_reset_n [*4])
		else $error("reset released early after supply rise");
	AST_EXT: assert property (!external_reset_pin [*8] |-> !system_reset_n)
		else $error("reset pin ignored");
	AST_WCLR: assert property ($fell(system_reset_n) |-> ##[0:1] wreg_clear)
		else $error("working regs not cleared");
	AST_BUS: assert property (hreadyout && !hresp && reset_vector == 24'h000000)
		else $error("bus answer or vector wrong");
	cover property ($rose(system_reset_n));
	cover property (wake_req);
	cover property (reset_instr && system_reset_n);
endmodule : rsf_monitor
bind rsf_top rsf_monitor u_mon (.*);
`default_nettype wire

/* File: verif/rsf_supervisor.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// external supervisor driving the reset pin
module rsf_supervisor #(
	parameter int LOW_CYC = 10
) (
	input wire logic clk, // system clock
	input wire logic req, // start one pulse
	output logic rst_pin_n // reset pin level
);
	int cnt_q = 0;
	always @(posedge clk) begin
		if (req) begin
			cnt_q <= LOW_CYC;
		end else if (cnt_q > 0) begin
			cnt_q <= cnt_q - 1;
		end
	end
	// held high between pulses: the pin has no pull-up and may not float
	assign rst_pin_n = (cnt_q == 0);
endmodule : rsf_supervisor
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
	import rsf_pkg::*;
	logic clk = 1'h0, sys_rst = 1'h1, brown_out_low = 1'h0, reset_instr = 1'h0, watchdog_timeout = 1'h0;
	logic cpu_sleep_idle = 1'h0, power_save_sleep = 1'h0, power_save_idle = 1'h0, hard_trap_req = 1'h0;
	logic watchdog_clear_instruction = 1'h0, opcode_valid = 1'h0, ptr_use = 1'h0, wreg_wr = 1'h0;
	logic program_flow_change = 1'h0, vector_flow_change = 1'h0, flow_target_restricted = 1'h0;
	logic hclk_unused = 1'h0, hsel = 1'h0, hwrite = 1'h0, xreq = 1'h0;
	logic [3:0] hard_trap_level = '0, active_trap_level = '0, ptr_reg_sel = '0, wreg_wr_sel = '0;
	logic [15:0] pin_select_regs = '0, pin_select_shadow = '0;
	logic [7:0] opcode_upper = '0, haddr = '0;
	logic [2:0] initial_clock_select = '0, current_clock_select = '0, hsize = 3'h2, clock_select;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = '0, hrdata, q;
	logic [23:0] reset_vector;
	logic hreadyout, hresp, system_reset_n, wreg_clear, wake_req;
	wire external_reset_pin;
	wire hready = hreadyout;
	int num_errors = 0, n_compared = 0, n, k;
	rsf_top #(.BROWN_EXT_CYC(4), .DELAY_UNIT_CYC(2)) u_dut (.*);
	rsf_supervisor u_sup (.clk(clk), .req(xreq), .rst_pin_n(external_reset_pin));
	initial begin
		forever #12.5 clk = ~clk;
	end
	// ==========================================
	// helpers
	task test_done;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : test_done
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge clk);
		while (hready !== 1'h1) @(posedge clk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'h1) @(posedge clk);
		q = hrdata;
	endtask : bus
	// bounded wait for release; n counts cycles after the first two
	task wait_up;
		n = 0;
		repeat (2) @(posedge clk);
		while (system_reset_n !== 1'h1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		chk("release", 1, n < 300);
	endtask : wait_up
	function logic [15:0] exp_flag(input int c);
		case (c)
			0: return 16'h0040;
			1: return 16'h0010;
			2: return 16'h8000;
			3: return 16'h0200;
			8: return 16'h0080;
			default: return 16'h4000;
		endcase
	endfunction : exp_flag
	task fire(input int c);
		@(posedge clk);
		case (c)
			0: reset_instr <= 1'h1;
			1: watchdog_timeout <= 1'h1;
			2: {hard_trap_req, hard_trap_level, active_trap_level} <= {1'h1, 4'hd, 4'he};
			3: pin_select_shadow <= ~pin_select_regs;
			4: {opcode_valid, opcode_upper} <= {1'h1, 8'h3f};
			5: {ptr_use, ptr_reg_sel} <= {1'h1, 4'($urandom_range(14, 0))};
			6: {program_flow_change, flow_target_restricted} <= 2'h3;
			7: {vector_flow_change, flow_target_restricted} <= 2'h3;
			8: xreq <= 1'h1;
			default: ;
		endcase
		@(posedge clk);
		{reset_instr, watchdog_timeout, hard_trap_req, opcode_valid, ptr_use} <= '0;
		{program_flow_change, vector_flow_change, flow_target_restricted, xreq} <= '0;
		{watchdog_clear_instruction, power_save_sleep, power_save_idle, wreg_wr} <= '0;
		pin_select_shadow <= pin_select_regs;
		// a pin pulse only bites after sync and filter: wait for the reset itself
		n = 0;
		while (c == 8 && system_reset_n !== 1'h0 && n < 40) begin
			@(posedge clk);
			n++;
		end
	endtask : fire
	initial begin
		#500000;
		num_errors++;
		test_done;
	end
	// ==========================================
	// scenarios
	initial begin
		void'($urandom(46607));
		repeat (3) @(posedge clk);
		sys_rst <= 1'h0;
		wait_up;
		bus(0, 8'h00, 0);
		chk("por_flags", 32'h0003, q);
		bus(0, 8'h0c, 0);
		chk("unmapped", 0, q);
		bus(1, 8'h00, 32'hffff);
		bus(0, 8'h00, 0);
		chk("flags_ones", 32'hc2df, q);
		chk("no_reset", 1, system_reset_n);
		bus(1, 8'h00, 0);
		for (k = 0; k < 9; k++) begin
			current_clock_select <= 3'($urandom_range(7, 0));
			fire(k);
			wait_up;
			bus(0, 8'h00, 0);
			chk("cause", exp_flag(k), q);
			bus(0, 8'h08, 0);
			chk("warm_clk", current_clock_select, q[3:1]);
			chk("warm_clk_out", current_clock_select, clock_select);
			bus(1, 8'h00, 0);
		end
		for (k = 0; k < 3; k++) begin
			fire(1);
			wait_up;
			{watchdog_clear_instruction, power_save_sleep, power_save_idle} <= 3'h4 >> k;
			fire(9);
			bus(0, 8'h00, 0);
			chk("wdt_clear", (k == 0) ? 0 : 32'h10 >> k, q);
			bus(1, 8'h00, 0);
		end
		@(posedge clk);
		{cpu_sleep_idle, watchdog_timeout, wreg_wr, wreg_wr_sel} <= {3'h7, 4'h3};
		@(negedge clk);
		chk("wake", 1, wake_req);
		@(posedge clk);
		{cpu_sleep_idle, watchdog_timeout, wreg_wr, ptr_use, ptr_reg_sel} <= {4'h1, 4'h3};
		{opcode_valid, opcode_upper} <= {1'h1, 8'($urandom_range(62, 0))};
		@(posedge clk);
		{ptr_use, opcode_valid} <= 2'h0;
		repeat (3) @(negedge clk);
		chk("stay_up", 1, system_reset_n);
		bus(1, 8'h04, 3);
		bus(0, 8'h04, 0);
		chk("cfg", 3, q);
		bus(1, 8'h00, 32'hffff);
		initial_clock_select <= current_clock_select ^ 3'($urandom_range(7, 1));
		brown_out_low <= 1'h1;
		repeat (5) @(posedge clk);
		brown_out_low <= 1'h0;
		repeat (10) @(posedge clk);
		chk("hold_clk_out", initial_clock_select, clock_select);
		brown_out_low <= 1'h1;
		repeat (3) @(posedge clk);
		brown_out_low <= 1'h0;
		// the oscillator model now runs the configured source
		current_clock_select <= initial_clock_select;
		wait_up;
		chk("brown_delay", 1, n + 2 >= 20 && n + 2 <= 28);
		bus(0, 8'h00, 0);
		chk("brown_flags", 32'h0083, q);
		bus(0, 8'h08, 0);
		chk("cold_clk", initial_clock_select, q[3:1]);
		chk("cold_clk_out", initial_clock_select, clock_select);
		test_done;
	end
endmodule : tb
`default_nettype wire
